// [src/smst_top.sv]
// Behaviour
// - Bandgap mismatch blocks regulator power-up
// - Safety variant: mismatch fails power-up test always
// - On, bypass 0: mismatch shuts regulators
// - On, bypass 1: mismatch only interrupts
// - Mismatch sets flag; unmasked flag interrupts
// - Sense bit follows present mismatch level
// - Self-test covers monitors and power-good pin
// - Each channel OV and UV comparator toggled
// - Non-toggling comparator sets channel fail bit
// - Separate OV and UV result registers
// - Every self-test overwrites both result registers
// - Result clears need secure write when enabled
// - Power-up continues whatever the self-test result
// - Writing trigger 1 starts on-demand self-test
// - Trigger clears itself when test finishes
// - OV/UV reporting blanked at most 200 us
// - On-demand failures set result flags
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "smst_defs.svh"
module smst_top #(
  parameter logic SAFETY_GRADE = 1'b1,
  parameter logic [15:0] BLANK_MAX_CYC = 16'(`SMST_BLANK_CYC)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_up_req,
  input wire logic power_down_req,
  input wire logic bg_mismatch,
  input wire logic [3:0] ov_cmp,
  input wire logic [3:0] uv_cmp,
  input wire logic power_good_req,
  input wire logic power_good_readback,
  output logic power_good_output,
  output logic [3:0] ov_test_force,
  output logic [3:0] uv_test_force,
  output logic [3:0] ov_fault_report,
  output logic [3:0] uv_fault_report,
  output logic regulator_enable,
  output logic bandgap_irq,
  output smst_pkg::smst_pwr_t pwr_state
);
  import smst_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  smst_analog_self_test_if ab ();
  smst_analog_self_test_seq u_seq (
    .clk(ref_clk),
    .rst_b(rst_sync_b),
    .ab(ab.seq)
  );

  smst_pwr_t state;
  smst_pwr_t next_state;
  logic trigger;
  logic bypass;
  logic sec_en;
  logic sec_armed;
  logic bg_q;
  logic bg_flag;
  logic irq_mask;
  logic [3:0] ov_res;
  logic [3:0] uv_res;
  logic pg_res;
  logic pu_fail;
  logic [15:0] blank_cnt;

  // APB decode; zero wait states, unmapped access answers pslverr
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire a_ctrl = hit(paddr, `SMST_CTRL_OFF);
  wire a_cfg = hit(paddr, `SMST_CFG_OFF);
  wire a_stat = hit(paddr, `SMST_STAT_OFF);
  wire a_iflag = hit(paddr, `SMST_IFLAG_OFF);
  wire a_imask = hit(paddr, `SMST_IMASK_OFF);
  wire a_ovres = hit(paddr, `SMST_OVRES_OFF);
  wire a_uvres = hit(paddr, `SMST_UVRES_OFF);
  wire a_key = hit(paddr, `SMST_KEY_OFF);
  wire mapped = a_ctrl | a_cfg | a_stat | a_iflag | a_imask | a_ovres | a_uvres | a_key;
  wire prot_ok = ~sec_en | sec_armed;
  wire w_res = wr_en & (a_ovres | a_uvres) & prot_ok;
  wire trig_start = wr_en & a_ctrl & pwdata[`SMST_CTRL_TRIG] & prot_ok
                    & ~trigger & ~ab.busy & (state == pwr_on);
  wire pu_start = (state == pwr_off) & power_up_req & ~ab.busy;
  wire bg_rise = bg_mismatch & ~bg_q;
  wire blank = trigger & (blank_cnt < BLANK_MAX_CYC);
  wire mon_quiet = blank | (state == pwr_test);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign ab.start = trig_start | pu_start;
  assign ab.cmp_ov = ov_cmp;
  assign ab.cmp_uv = uv_cmp;
  assign ab.pg_readback = power_good_readback;
  assign ov_test_force = ab.force_ov;
  assign uv_test_force = ab.force_uv;
  assign regulator_enable = (state == pwr_on);
  assign pwr_state = state;

  always_comb
  begin
    next_state = state;
    case (state)
      pwr_off:
        if (pu_start)
          next_state = pwr_test;
      pwr_test:
        if (bg_mismatch)
          next_state = pwr_block;
        else if (ab.done)
          next_state = pwr_on;
      pwr_on:
        if (power_down_req)
          next_state = pwr_off;
        else if (bg_mismatch && !bypass)
          next_state = pwr_shut;
      pwr_block, pwr_shut:
        if (power_down_req)
          next_state = pwr_off;
      default:
        next_state = pwr_off;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      state <= pwr_off;
    else
      state <= next_state;
  end

  // Bypass ignored at power-up: the safety variant must never start on a bad reference
  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      pu_fail <= 1'b0;
    else if (pu_start)
      pu_fail <= 1'b0;
    else if (state == pwr_test && bg_mismatch && SAFETY_GRADE)
      pu_fail <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      {sec_en, bypass} <= `SMST_CFG_RST;
      irq_mask <= `SMST_IMASK_RST;
      sec_armed <= 1'b0;
    end
    else if (wr_en)
    begin
      if (a_cfg)
      begin
        bypass <= pwdata[`SMST_CFG_BYPASS];
        sec_en <= pwdata[`SMST_CFG_SECEN];
      end
      if (a_imask)
        irq_mask <= pwdata[`SMST_IRQ_BG];
      // The key arms exactly the next write, whatever it targets
      sec_armed <= a_key & (pwdata == `SMST_SEC_KEY);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      trigger <= 1'b0;
    else if (trig_start)
      trigger <= 1'b1;
    else if (ab.done)
      trigger <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      blank_cnt <= 16'h0000;
    else if (!trigger)
      blank_cnt <= 16'h0000;
    else if (blank)
      blank_cnt <= blank_cnt + 16'h0001;
  end

  // Completion outranks a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      ov_res <= 4'h0;
      uv_res <= 4'h0;
      pg_res <= 1'b0;
    end
    else if (ab.done)
    begin
      ov_res <= ab.ov_fail;
      uv_res <= ab.uv_fail;
      pg_res <= ab.pg_fail;
    end
    else if (ab.start)
    begin
      ov_res <= 4'h0;
      uv_res <= 4'h0;
      pg_res <= 1'b0;
    end
    else if (w_res)
    begin
      if (a_ovres)
        ov_res <= ov_res & ~pwdata[3:0];
      if (a_uvres)
        uv_res <= uv_res & ~pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      bg_q <= 1'b0;
      bg_flag <= 1'b0;
      bandgap_irq <= 1'b0;
    end
    else
    begin
      bg_q <= bg_mismatch;
      if (bg_rise)
        bg_flag <= 1'b1;
      else if (wr_en && a_iflag && pwdata[`SMST_IRQ_BG])
        bg_flag <= 1'b0;
      bandgap_irq <= bg_flag & ~irq_mask;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      ov_fault_report <= 4'h0;
      uv_fault_report <= 4'h0;
      power_good_output <= 1'b0;
    end
    else
    begin
      ov_fault_report <= mon_quiet ? 4'h0 : ov_cmp;
      uv_fault_report <= mon_quiet ? 4'h0 : uv_cmp;
      power_good_output <= power_good_req & ~ab.force_pg;
    end
  end

  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (a_ctrl)
      rd_data[`SMST_CTRL_TRIG] = trigger;
    if (a_cfg)
      rd_data[1:0] = {sec_en, bypass};
    if (a_stat)
      rd_data[6:0] = {regulator_enable, pu_fail, pg_res, state == pwr_shut,
                      state == pwr_block, ab.busy, bg_q};
    if (a_iflag)
      rd_data[`SMST_IRQ_BG] = bg_flag;
    if (a_imask)
      rd_data[`SMST_IRQ_BG] = irq_mask;
    if (a_ovres)
      rd_data[3:0] = ov_res;
    if (a_uvres)
      rd_data[3:0] = uv_res;
  end

  // Read data captured in the setup phase so prdata comes from a flop
  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_data;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_b);

  property p_bg_block;
    state == pwr_test && bg_mismatch |=> state == pwr_block && !regulator_enable;
  endproperty
  a_bg_block: assert property (p_bg_block) else $error("mismatch did not block");
  property p_pu_fail;
    state == pwr_test && bg_mismatch && SAFETY_GRADE |=> pu_fail;
  endproperty
  a_pu_fail: assert property (p_pu_fail) else $error("power-up test not failed");
  property p_bg_shut;
    state == pwr_on && bg_mismatch && !bypass && !power_down_req
      |=> state == pwr_shut ##1 !regulator_enable;
  endproperty
  a_bg_shut: assert property (p_bg_shut) else $error("regulators not shut");
  property p_bg_keep;
    state == pwr_on && bg_mismatch && bypass && !power_down_req
      |=> regulator_enable ##2 bandgap_irq || irq_mask || !bg_flag;
  endproperty
  a_bg_keep: assert property (p_bg_keep) else $error("bypass did not keep running");
  property p_irq;
    bg_rise && !irq_mask ##1 !irq_mask |=> bandgap_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked flag gave no irq");
  property p_sense;
    setup && !pwrite && a_stat |=> prdata[`SMST_ST_SENSE] == $past(bg_q);
  endproperty
  a_sense: assert property (p_sense) else $error("sense bit wrong");
  property p_result;
    ab.done |=> ov_res == $past(ab.ov_fail) && uv_res == $past(ab.uv_fail);
  endproperty
  a_result: assert property (p_result) else $error("results not overwritten");
  property p_protect;
    wr_en && a_ovres && !prot_ok && !ab.done && !ab.start |=> $stable(ov_res);
  endproperty
  a_protect: assert property (p_protect) else $error("unsecured clear accepted");
  property p_self_clear;
    trigger && ab.done |=> !trigger && !blank;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("trigger not cleared");
  // While on and outside blanking, every report must track its comparator one cycle later
  property p_blank_max;
    state == pwr_on && !blank
      |=> ov_fault_report == $past(ov_cmp) && uv_fault_report == $past(uv_cmp);
  endproperty
  a_blank_max: assert property (p_blank_max) else $error("reporting not resumed");
  property p_start;
    trig_start |=> trigger && ab.busy;
  endproperty
  a_start: assert property (p_start) else $error("trigger did not start test");

  c_on_demand: cover property (trigger && ab.done && blank_cnt < BLANK_MAX_CYC);
  c_shut: cover property (state == pwr_on ##1 state == pwr_shut);
  c_secure_clear: cover property (sec_en && w_res);
endmodule : smst_top
`default_nettype wire

// [src/smst_defs.svh]
`ifndef SMST_DEFS_SVH
`define SMST_DEFS_SVH

`define SMST_AW 8
`define SMST_NCH 4

// Register byte offsets
`define SMST_CTRL_OFF 8'h00
`define SMST_CFG_OFF 8'h04
`define SMST_STAT_OFF 8'h08
`define SMST_IFLAG_OFF 8'h0c
`define SMST_IMASK_OFF 8'h10
`define SMST_OVRES_OFF 8'h14
`define SMST_UVRES_OFF 8'h18
`define SMST_KEY_OFF 8'h1c

// Field positions
`define SMST_CTRL_TRIG 0
`define SMST_CFG_BYPASS 0
`define SMST_CFG_SECEN 1
`define SMST_IRQ_BG 0
`define SMST_ST_SENSE 0
`define SMST_ST_BUSY 1
`define SMST_ST_BLOCK 2
`define SMST_ST_SHUT 3
`define SMST_ST_PGFAIL 4
`define SMST_ST_PUFAIL 5
`define SMST_ST_ON 6

// Reset values and security key
`define SMST_CFG_RST 2'h0
`define SMST_IMASK_RST 1'h0
`define SMST_SEC_KEY 32'h0000c35a

// Timing
`define SMST_CLK_NS 40
`define SMST_STEP_NS 8000
`define SMST_STEP_CYC ((`SMST_STEP_NS + `SMST_CLK_NS - 1) / `SMST_CLK_NS)
`define SMST_BLANK_US 200
`define SMST_BLANK_CYC ((`SMST_BLANK_US * 1000) / `SMST_CLK_NS)

`endif

// [src/smst_pkg.sv]
package smst_pkg;
  typedef enum logic [2:0] {pwr_off, pwr_test, pwr_on, pwr_block, pwr_shut} smst_pwr_t;
  typedef enum logic [1:0] {seq_idle, seq_force, seq_release} smst_seq_t;
endpackage : smst_pkg

// [src/smst_analog_self_test_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface smst_analog_self_test_if;
  logic start;
  logic busy;
  logic done;
  logic [3:0] ov_fail;
  logic [3:0] uv_fail;
  logic pg_fail;
  logic [3:0] cmp_ov;
  logic [3:0] cmp_uv;
  logic pg_readback;
  logic [3:0] force_ov;
  logic [3:0] force_uv;
  logic force_pg;
  modport ctl (
    output start, cmp_ov, cmp_uv, pg_readback,
    input busy, done, ov_fail, uv_fail, pg_fail, force_ov, force_uv, force_pg
  );
  modport seq (
    input start, cmp_ov, cmp_uv, pg_readback,
    output busy, done, ov_fail, uv_fail, pg_fail, force_ov, force_uv, force_pg
  );
endinterface : smst_analog_self_test_if
`default_nettype wire

// [src/smst_analog_self_test_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smst_defs.svh"
module smst_analog_self_test_seq (
  input wire logic clk,
  input wire logic rst_b,
  smst_analog_self_test_if.seq ab
);
  import smst_pkg::*;

  localparam logic [3:0] LAST_STEP = 4'h8;
  localparam logic [7:0] STEP_END = 8'(`SMST_STEP_CYC - 1);

  smst_seq_t st;
  logic [3:0] step;
  logic [7:0] cnt;
  logic [8:0] fail_q;
  logic done_q;
  wire forcing = (st == seq_force);
  wire step_end = (st != seq_idle) && (cnt == STEP_END);
  // Power-good is driven low while forced; seen only while forced
  wire pg_obs = ab.force_pg & ~ab.pg_readback;
  wire obs = (step < 4'h4) ? ab.cmp_ov[step[1:0]] :
             (step < 4'h8) ? ab.cmp_uv[step[1:0]] : pg_obs;

  genvar i;
  generate
    for (i = 0; i < `SMST_NCH; i++)
    begin : g_force
      assign ab.force_ov[i] = forcing && (step == 4'(i));
      assign ab.force_uv[i] = forcing && (step == 4'(i + 4));
    end
  endgenerate
  assign ab.force_pg = forcing && (step == LAST_STEP);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= seq_idle;
      step <= 4'h0;
      cnt <= 8'h00;
      fail_q <= 9'h000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      cnt <= step_end ? 8'h00 : cnt + 8'h01;
      case (st)
        seq_idle:
        begin
          cnt <= 8'h00;
          if (ab.start)
          begin
            st <= seq_force;
            step <= 4'h0;
            fail_q <= 9'h000;
          end
        end
        seq_force:
          if (step_end)
          begin
            // Comparator must trip while stimulated
            if (!obs)
              fail_q[step] <= 1'b1;
            st <= seq_release;
          end
        seq_release:
          if (step_end)
          begin
            // And must fall back once released, else it is stuck
            if (obs)
              fail_q[step] <= 1'b1;
            if (step == LAST_STEP)
            begin
              st <= seq_idle;
              done_q <= 1'b1;
            end
            else
            begin
              step <= step + 4'h1;
              st <= seq_force;
            end
          end
        default:
          st <= seq_idle;
      endcase
    end
  end

  assign ab.busy = (st != seq_idle);
  assign ab.done = done_q;
  assign ab.ov_fail = fail_q[3:0];
  assign ab.uv_fail = fail_q[7:4];
  assign ab.pg_fail = fail_q[8];
endmodule : smst_analog_self_test_seq
`default_nettype wire

// [tb/smst_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smst_analog_model (
  input wire logic [3:0] ov_force,
  input wire logic [3:0] uv_force,
  input wire logic [3:0] ov_trip,
  input wire logic [3:0] uv_trip,
  input wire logic [3:0] ov_stuck,
  input wire logic [3:0] uv_stuck,
  input wire logic pg_stuck,
  input wire logic pg_out,
  output logic [3:0] ov_cmp,
  output logic [3:0] uv_cmp,
  output logic pg_readback
);
  // A stuck comparator never trips, so a forced step must see it fail to toggle
  assign ov_cmp = (ov_force | ov_trip) & ~ov_stuck;
  assign uv_cmp = (uv_force | uv_trip) & ~uv_stuck;
  // A shorted pin reads high even while the test pulls it low
  assign pg_readback = pg_out | pg_stuck;
endmodule : smst_analog_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smst_defs.svh"
module tb_top;
  import smst_pkg::*;
  localparam logic [15:0] BLANK = 16'd4000;
  localparam logic [7:0] A_CTRL = `SMST_CTRL_OFF;
  localparam logic [7:0] A_CFG = `SMST_CFG_OFF;
  localparam logic [7:0] A_STAT = `SMST_STAT_OFF;
  localparam logic [7:0] A_IFLAG = `SMST_IFLAG_OFF;
  localparam logic [7:0] A_IMASK = `SMST_IMASK_OFF;
  localparam logic [7:0] A_OV = `SMST_OVRES_OFF;
  localparam logic [7:0] A_UV = `SMST_UVRES_OFF;
  localparam logic [7:0] A_KEY = `SMST_KEY_OFF;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic power_up_req, power_down_req, bg_mismatch, power_good_req, power_good_readback;
  logic power_good_output, regulator_enable, bandgap_irq, pg_stuck;
  logic [3:0] ov_cmp, uv_cmp, ov_test_force, uv_test_force, ov_fault_report, uv_fault_report;
  logic [3:0] ov_stuck, uv_stuck, ov_trip, uv_trip;
  smst_pwr_t pwr_state;
  int errors, samples_checked, cyc;

  smst_top #(.SAFETY_GRADE(1'b1), .BLANK_MAX_CYC(BLANK)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_up_req(power_up_req), .power_down_req(power_down_req), .bg_mismatch(bg_mismatch),
    .ov_cmp(ov_cmp), .uv_cmp(uv_cmp), .power_good_req(power_good_req),
    .power_good_readback(power_good_readback), .power_good_output(power_good_output),
    .ov_test_force(ov_test_force), .uv_test_force(uv_test_force),
    .ov_fault_report(ov_fault_report), .uv_fault_report(uv_fault_report),
    .regulator_enable(regulator_enable), .bandgap_irq(bandgap_irq), .pwr_state(pwr_state)
  );
  smst_analog_model analog (
    .ov_force(ov_test_force), .uv_force(uv_test_force), .ov_trip(ov_trip), .uv_trip(uv_trip),
    .ov_stuck(ov_stuck), .uv_stuck(uv_stuck), .pg_stuck(pg_stuck),
    .pg_out(power_good_output), .ov_cmp(ov_cmp), .uv_cmp(uv_cmp),
    .pg_readback(power_good_readback)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // No wait-state count is assumed; only the watchdog ends a stuck wait
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task pulse_up;
    int n;
    n = 0;
    @(posedge ref_clk);
    power_up_req <= 1'b1;
    // Held as a level: a sequencer still busy from a blocked start refuses it
    while (pwr_state === pwr_off && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
    power_up_req <= 1'b0;
  endtask : pulse_up

  task go_off;
    @(posedge ref_clk);
    power_down_req <= 1'b1;
    @(posedge ref_clk);
    power_down_req <= 1'b0;
    wait_state(pwr_off);
  endtask : go_off

  task wait_state(input smst_pwr_t s);
    int n;
    n = 0;
    while (pwr_state !== s && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(pwr_state, s);
  endtask : wait_state

  task wait_trig;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 3000)
    begin
      apb(1'b0, A_CTRL, 32'h0);
      n++;
    end
    chk(rd[0], 1'b0);
  endtask : wait_trig

  task t_block;
    wr(A_CFG, 32'h1);
    bg_mismatch <= 1'b1;
    pulse_up();
    wait_state(pwr_block);
    chk(regulator_enable, 1'b0);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[`SMST_ST_BLOCK], 1'b1);
    chk(rd[`SMST_ST_PUFAIL], 1'b1);
    bg_mismatch <= 1'b0;
    go_off();
    wr(A_CFG, 32'h0);
    wr(A_IFLAG, 32'h1);
    $display("test block done");
  endtask : t_block

  task t_powerup;
    int n;
    ov_stuck <= 4'h4;
    pulse_up();
    n = 0;
    while (ov_test_force === 4'h0 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (100) @(posedge ref_clk);
    chk({uv_test_force, ov_test_force}, 8'h01);
    chk(ov_fault_report, 4'h0);
    repeat (400) @(posedge ref_clk);
    chk({uv_test_force, ov_test_force}, 8'h02);
    repeat (1600) @(posedge ref_clk);
    chk({uv_test_force, ov_test_force}, 8'h20);
    repeat (1200) @(posedge ref_clk);
    chk(power_good_output, 1'b0);
    wait_state(pwr_on);
    chk(regulator_enable, 1'b1);
    rdchk(A_OV, 32'h4);
    rdchk(A_UV, 32'h0);
    ov_stuck <= 4'h0;
    $display("test power-up done");
  endtask : t_powerup

  task t_ondemand;
    int t0;
    uv_stuck <= 4'h2;
    t0 = cyc;
    wr(A_CTRL, 32'h1);
    rdchk(A_CTRL, 32'h1);
    repeat (60) @(posedge ref_clk);
    chk(ov_cmp[0], 1'b1);
    chk(ov_fault_report, 4'h0);
    wait_trig();
    chk(32'(cyc - t0 <= int'(BLANK)), 32'h1);
    rdchk(A_OV, 32'h0);
    rdchk(A_UV, 32'h2);
    uv_stuck <= 4'h0;
    ov_trip <= 4'h9;
    uv_trip <= 4'h6;
    repeat (3) @(posedge ref_clk);
    chk(ov_fault_report, 4'h9);
    chk(uv_fault_report, 4'h6);
    ov_trip <= 4'h0;
    uv_trip <= 4'h0;
    $display("test on-demand done");
  endtask : t_ondemand

  task t_bandgap;
    wr(A_CFG, 32'h1);
    bg_mismatch <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(bandgap_irq, 1'b1);
    chk(pwr_state, pwr_on);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[`SMST_ST_SENSE], 1'b1);
    rdchk(A_IFLAG, 32'h1);
    bg_mismatch <= 1'b0;
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[`SMST_ST_SENSE], 1'b0);
    wr(A_IMASK, 32'h1);
    wr(A_IFLAG, 32'h1);
    rdchk(A_IFLAG, 32'h0);
    bg_mismatch <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(A_IFLAG, 32'h1);
    chk(bandgap_irq, 1'b0);
    bg_mismatch <= 1'b0;
    wr(A_IFLAG, 32'h1);
    wr(A_IMASK, 32'h0);
    wr(A_CFG, 32'h0);
    bg_mismatch <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(pwr_state, pwr_shut);
    chk(regulator_enable, 1'b0);
    bg_mismatch <= 1'b0;
    go_off();
    $display("test bandgap done");
  endtask : t_bandgap

  task t_secure;
    pg_stuck <= 1'b1;
    ov_stuck <= 4'h8;
    pulse_up();
    wait_state(pwr_on);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[`SMST_ST_PGFAIL], 1'b1);
    pg_stuck <= 1'b0;
    wr(A_CFG, 32'h2);
    wr(A_OV, 32'hf);
    rdchk(A_OV, 32'h8);
    wr(A_KEY, `SMST_SEC_KEY);
    wr(A_OV, 32'hf);
    rdchk(A_OV, 32'h0);
    wr(A_CTRL, 32'h1);
    rdchk(A_CTRL, 32'h0);
    wr(A_KEY, `SMST_SEC_KEY);
    wr(A_CTRL, 32'h1);
    rdchk(A_CTRL, 32'h1);
    wait_trig();
    rdchk(A_OV, 32'h8);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    ov_stuck <= 4'h0;
    $display("test secure done");
  endtask : t_secure

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  initial
  begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {power_up_req, power_down_req, bg_mismatch, pg_stuck} = '0;
    {ov_stuck, uv_stuck, ov_trip, uv_trip} = '0;
    power_good_req = 1'b1;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_block();
    t_powerup();
    t_ondemand();
    t_bandgap();
    t_secure();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
